// [dv/seqo_output_cfg_asserts.sv]
// port assertions for the enable-output configuration block
`default_nettype none

module seqo_output_cfg_asserts #(
    parameter int CHANNELS = 12
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // slots and pins
    input wire logic [11:0] slot_on,
    input wire logic [11:0] en_out_in,
    input wire logic [11:0] en_out_o,
    input wire logic [11:0] en_out_oe,
    // helpers and health
    input wire logic [5:0] pump_on,
    input wire logic [3:0] track_on,
    input wire logic [3:0] sense_pair_req,
    input wire logic [11:0] bad_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // fully writable registers
    logic map_hit;
    assign map_hit = reg_addr inside {8'h1F, 8'h20, 8'h21};

    // register port behaviour
    property p_unmap;
        !(map_hit || reg_addr == 8'h22) |=> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_rsvd;
        reg_addr == 8'h22 |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits read back set");
    property p_wrback;
        reg_wr && map_hit ##1 $stable(reg_addr)
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_wrback: assert property (p_wrback)
        else $error("written value not read back");

    // relations between decoded outputs
    property p_pump;
        |pump_on |-> (pump_on & en_out_oe[5:0]) == 6'h00;
    endproperty
    a_pump: assert property (p_pump)
        else $error("pin driven while pump on");
    property p_trk;
        (track_on & (~sense_pair_req | en_out_oe[3:0])) == 4'h0;
    endproperty
    a_trk: assert property (p_trk)
        else $error("tracking without pairing or with drive");
    property p_bad;
        (bad_mode & en_out_oe) == 12'h000;
    endproperty
    a_bad: assert property (p_bad)
        else $error("reserved code drives pin");
    property p_ch8;
        ((en_out_o | en_out_oe) >> CHANNELS) == 12'h000;
    endproperty
    a_ch8: assert property (p_ch8)
        else $error("absent channel active");
    property p_hold;
        $past(reset_n) && $stable(slot_on) && !$past(reg_wr)
            |=> $stable(en_out_o) && $stable(en_out_oe);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pin moved without cause");

    // main scenarios reached
    c_pump: cover property (|pump_on);
    c_trk: cover property (|track_on);
    c_bad: cover property (|bad_mode);
endmodule : seqo_output_cfg_asserts

bind seqo_output_cfg seqo_output_cfg_asserts #(.CHANNELS(CHANNELS)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .slot_on(slot_on), .en_out_in(en_out_in), .en_out_o(en_out_o),
    .en_out_oe(en_out_oe), .pump_on(pump_on), .track_on(track_on),
    .sense_pair_req(sense_pair_req), .bad_mode(bad_mode));

`default_nettype wire

// [dv/seqo_supply_model.sv]
// pulled-up supply enable inputs on the far side of the pins
`default_nettype none

module seqo_supply_model (
    // pin drive from the device
    input wire logic [11:0] pin_o,
    input wire logic [11:0] pin_oe,
    // level seen on each wire
    output logic [11:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // released pins float to the pull-up level
    assign pin_lvl = (pin_oe & pin_o) | ~pin_oe;
endmodule : seqo_supply_model

`default_nettype wire

// [dv/test_sequencer_output_config.sv]
// self-checking bench for the enable-output configuration block
`default_nettype none

module test_sequencer_output_config;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, reset_n, reg_wr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [11:0] slot_on, lvl, en_out_o, en_out_oe, bad_mode, oe8;
    logic [5:0] pump_on, got, want;
    logic [3:0] track_on, sense_pair_req;
    logic [8:0] r;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    // ch1 code, slot, then pin level, oe, pump, track, bad
    logic [8:0] rows [16] = '{
        9'h010, 9'h028, 9'h048, 9'h070, 9'h098, 9'h0A8, 9'h0C8, 9'h0F8,
        9'h110, 9'h132, 9'h148, 9'h174, 9'h191, 9'h1B1, 9'h1D1, 9'h1F1};

    // twelve- and eight-channel builds share the register traffic
    seqo_output_cfg u_dut (
        .core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .slot_on(slot_on), .en_out_in(lvl), .en_out_o(en_out_o),
        .en_out_oe(en_out_oe), .pump_on(pump_on), .track_on(track_on),
        .sense_pair_req(sense_pair_req), .bad_mode(bad_mode));
    seqo_output_cfg #(.CHANNELS(8)) u_dut8 (
        .core_clk(core_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(),
        .slot_on(slot_on), .en_out_in(lvl), .en_out_o(), .en_out_oe(oe8),
        .pump_on(), .track_on(), .sense_pair_req(), .bad_mode());
    seqo_supply_model u_supply (
        .pin_o(en_out_o), .pin_oe(en_out_oe), .pin_lvl(lvl));

    // clock and hang guard
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            test_done();
        end
    end

    task automatic chk(input logic [11:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1;
        reg_wr = 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, exp);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        chk(12'(reg_rdata), 12'(exp), "rdata");
    endtask : rd

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        reset_n = 1'h0;
        reg_wr = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        slot_on = 12'h000;
        repeat (5) @(posedge core_clk);
        #1;
        reset_n = 1'h1;
        for (int a = 8'h1F; a <= 8'h22; a++) begin
            rd(8'(a), 8'h00);
        end
        $display("reset values done");
        // every channel-one code with its slot low and high
        foreach (rows[i]) begin
            r = rows[i];
            wr(8'h1F, {5'h00, r[8:6]});
            slot_on = {11'h000, r[5]};
            @(posedge core_clk);
            #1;
            got = {sense_pair_req[0], lvl[0], en_out_oe[0], pump_on[0],
                track_on[0], bad_mode[0]};
            want = {r[8:6] == 3'h4, r[4:0]};
            chk(12'(got), 12'(want), "ch1");
        end
        $display("channel one codes done");
        // push-pull and pump codes on every channel, all slots asserted
        wr(8'h1F, 8'h53);
        wr(8'h20, 8'hB5);
        wr(8'h21, 8'hBA);
        wr(8'h22, 8'hFB);
        slot_on = 12'hFFF;
        @(posedge core_clk);
        #1;
        chk(lvl, 12'hAB5, "level");
        chk(en_out_oe, 12'hFDB, "oe");
        chk(12'(pump_on), 12'h024, "pump");
        chk(bad_mode, 12'h000, "bad");
        chk(oe8, 12'h0DB, "oe8");
        rd(8'h22, 8'h3B);
        rd(8'h21, 8'hBA);
        $display("field map done");
        // tracking code on channel five, then a stray write
        wr(8'h20, 8'hC5);
        wr(8'h23, 8'hFF);
        @(posedge core_clk);
        #1;
        chk(bad_mode, 12'h010, "bad");
        chk(en_out_oe, 12'hFCB, "oe");
        chk(12'(track_on), 12'h000, "track");
        rd(8'h23, 8'h00);
        rd(8'h20, 8'hC5);
        $display("refusals done");
        // reset in mid-run releases every pin and clears config
        reset_n = 1'h0;
        @(posedge core_clk);
        #1;
        chk(en_out_oe, 12'h000, "oe reset");
        reset_n = 1'h1;
        rd(8'h20, 8'h00);
        $display("mid-run reset done");
        test_done();
    end
endmodule : test_sequencer_output_config

`default_nettype wire

// [hw/seqo_chan_if.sv]
// per-channel carrier between the decoder and the output stage
`default_nettype none

interface seqo_chan_if;
    import seqo_pkg::*;

    seqo_drive_t drive;
    logic pin_out;
    logic pin_oe;
    logic pump_on;
    logic track_on;
    logic bad_mode;

    // decoder side
    modport ctl (
        output drive,
        input pin_out,
        input pin_oe,
        input pump_on,
        input track_on,
        input bad_mode
    );

    // output stage side
    modport stage (
        input drive,
        output pin_out,
        output pin_oe,
        output pump_on,
        output track_on,
        output bad_mode
    );
endinterface : seqo_chan_if

`default_nettype wire

// [hw/seqo_map.svh]
// register offsets, field positions, reset values and notes for seqo
//
// Notes on behaviour
// - channels 1-4 decode 3-bit codes: OD/PP low/high, 100 tracking.
// - ch1-6: code 101 selects charge-pump gate drive from rail input.
// - channels 7-12 decode 2-bit codes: OD/PP, active low or high.
// - cfg_a: ch1 bits 2..0, ch2 bits 5..3, ch3 low bits 7..6.
// - cfg_b: ch3 top in bit 0, ch4 3..1, ch5 6..4, ch6 low bit 7.
// - cfg_c: ch6 top bits 1..0, ch7 3..2, ch8 5..4, ch9 7..6.
// - cfg_d: ch10 1..0, ch11 3..2, ch12 5..4, bits 7..6 reserved.
// - 12-channel build drives all; 8-channel build ignores fields 9-12.
// - on the channels a build drives (1-12 or 1-8), each output asserts while its slot request is on, in every mode that does not raise bad_mode.
`ifndef SEQO_MAP_SVH
`define SEQO_MAP_SVH

// register offsets
`define SEQO_OFS_CFG_A 8'h1F
`define SEQO_OFS_CFG_B 8'h20
`define SEQO_OFS_CFG_C 8'h21
`define SEQO_OFS_CFG_D 8'h22

// reset values: every channel open-drain active-low
`define SEQO_RST_CFG_A 8'h00
`define SEQO_RST_CFG_B 8'h00
`define SEQO_RST_CFG_C 8'h00
`define SEQO_RST_CFG_D 8'h00

// writable bits of cfg_d, the top two are reserved
`define SEQO_CFG_D_MASK 8'h3F

// field positions, low bit of each field
`define SEQO_CH1_LSB 0
`define SEQO_CH2_LSB 3
`define SEQO_CH3_LO_LSB 6
`define SEQO_CH3_HI_BIT 0
`define SEQO_CH4_LSB 1
`define SEQO_CH5_LSB 4
`define SEQO_CH6_LO_BIT 7
`define SEQO_CH6_HI_LSB 0
`define SEQO_CH7_LSB 2
`define SEQO_CH8_LSB 4
`define SEQO_CH9_LSB 6
`define SEQO_CH10_LSB 0
`define SEQO_CH11_LSB 2
`define SEQO_CH12_LSB 4

// channel capability limits
`define SEQO_MAX_CH 12
`define SEQO_TRACK_CH 4
`define SEQO_PUMP_CH 6
`define SEQO_WIDE_CH 6

`endif

// [hw/seqo_out_stage.sv]
// registered output stage of one enable channel
`default_nettype none

module seqo_out_stage (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // decoded drive
    seqo_chan_if.stage chan
);
    import seqo_pkg::*;

    logic pin_out_r;
    logic pin_oe_r;
    logic pump_on_r;
    logic track_on_r;
    logic bad_mode_r;

    // pins released and every helper off until the first clock after reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_out_r <= 1'h0;
            pin_oe_r <= 1'h0;
            pump_on_r <= 1'h0;
            track_on_r <= 1'h0;
            bad_mode_r <= 1'h0;
        end else begin
            pin_out_r <= chan.drive.pin_out;
            pin_oe_r <= chan.drive.pin_oe;
            pump_on_r <= chan.drive.pump_on;
            track_on_r <= chan.drive.track_on;
            bad_mode_r <= chan.drive.bad_mode;
        end
    end

    // flops feed the pins directly
    assign chan.pin_out = pin_out_r;
    assign chan.pin_oe = pin_oe_r;
    assign chan.pump_on = pump_on_r;
    assign chan.track_on = track_on_r;
    assign chan.bad_mode = bad_mode_r;

endmodule : seqo_out_stage

`default_nettype wire

// [hw/seqo_output_cfg.sv]
// enable-output configuration registers and per-channel drive decode
`include "seqo_map.svh"
`default_nettype none

module seqo_output_cfg #(
    parameter int CHANNELS = 12
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // sequencer slot requests
    input wire logic [11:0] slot_on,
    // enable pins, three signals per pin
    input wire logic [11:0] en_out_in,
    output logic [11:0] en_out_o,
    output logic [11:0] en_out_oe,
    // analog helper controls
    output logic [5:0] pump_on,
    output logic [3:0] track_on,
    output logic [3:0] sense_pair_req,
    // configuration health
    output logic [11:0] bad_mode
);
    import seqo_pkg::*;

    // only the two documented builds are served
    generate
        if (CHANNELS != 8 && CHANNELS != 12) begin : g_bad_channels
            $error("seqo_output_cfg: CHANNELS must be 8 or 12");
        end
    endgenerate

    logic [7:0] cfg_a_r;
    logic [7:0] cfg_b_r;
    logic [7:0] cfg_c_r;
    logic [7:0] cfg_d_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [3:0] sense_req_r;

    // address decode
    wire hit_a = (reg_addr == `SEQO_OFS_CFG_A);
    wire hit_b = (reg_addr == `SEQO_OFS_CFG_B);
    wire hit_c = (reg_addr == `SEQO_OFS_CFG_C);
    wire hit_d = (reg_addr == `SEQO_OFS_CFG_D);

    // configuration register writes
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_a_r <= `SEQO_RST_CFG_A;
            cfg_b_r <= `SEQO_RST_CFG_B;
            cfg_c_r <= `SEQO_RST_CFG_C;
            cfg_d_r <= `SEQO_RST_CFG_D;
        end else if (reg_wr) begin
            if (hit_a) begin
                cfg_a_r <= reg_wdata;
            end else if (hit_b) begin
                cfg_b_r <= reg_wdata;
            end else if (hit_c) begin
                cfg_c_r <= reg_wdata;
            end else if (hit_d) begin
                cfg_d_r <= reg_wdata & `SEQO_CFG_D_MASK;
            end
        end
    end

    // read selection, unmapped offsets read zero
    always_comb begin
        if (hit_a) begin
            rdata_nxt = cfg_a_r;
        end else if (hit_b) begin
            rdata_nxt = cfg_b_r;
        end else if (hit_c) begin
            rdata_nxt = cfg_c_r;
        end else if (hit_d) begin
            rdata_nxt = cfg_d_r;
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // read data registered, one cycle after the address
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // field extraction into one 3-bit code per channel
    logic [2:0] code [`SEQO_MAX_CH];

    assign code[0] = cfg_a_r[`SEQO_CH1_LSB +: 3];
    assign code[1] = cfg_a_r[`SEQO_CH2_LSB +: 3];
    assign code[2] = {cfg_b_r[`SEQO_CH3_HI_BIT],
                      cfg_a_r[`SEQO_CH3_LO_LSB +: 2]};
    assign code[3] = cfg_b_r[`SEQO_CH4_LSB +: 3];
    assign code[4] = cfg_b_r[`SEQO_CH5_LSB +: 3];
    assign code[5] = {cfg_c_r[`SEQO_CH6_HI_LSB +: 2],
                      cfg_b_r[`SEQO_CH6_LO_BIT]};
    // narrow channels carry a zero top bit
    assign code[6] = {1'h0, cfg_c_r[`SEQO_CH7_LSB +: 2]};
    assign code[7] = {1'h0, cfg_c_r[`SEQO_CH8_LSB +: 2]};
    assign code[8] = {1'h0, cfg_c_r[`SEQO_CH9_LSB +: 2]};
    assign code[9] = {1'h0, cfg_d_r[`SEQO_CH10_LSB +: 2]};
    assign code[10] = {1'h0, cfg_d_r[`SEQO_CH11_LSB +: 2]};
    assign code[11] = {1'h0, cfg_d_r[`SEQO_CH12_LSB +: 2]};

    // per-channel decode and output stage
    genvar ch;
    generate
        for (ch = 0; ch < `SEQO_MAX_CH; ch++) begin : g_ch
            localparam bit PRESENT = (ch < CHANNELS);
            localparam bit CAN_TRACK = (ch < `SEQO_TRACK_CH);
            localparam bit CAN_PUMP = (ch < `SEQO_PUMP_CH);

            seqo_chan_if chan_if ();
            seqo_mode_t mode;
            seqo_drive_t drv;
            logic on;

            assign mode = seqo_mode_t'(code[ch]);
            // slot request asserts the output of a present channel in every mode that does not raise bad_mode
            assign on = slot_on[ch];

            // mode to pin behaviour
            always_comb begin
                drv = '0;
                if (!PRESENT) begin
                    drv = '0;
                end else begin
                    case (mode)
                        SEQO_OD_LOW: begin
                            drv.pin_out = 1'h0;
                            drv.pin_oe = on;
                        end
                        SEQO_OD_HIGH: begin
                            drv.pin_out = 1'h0;
                            drv.pin_oe = !on;
                        end
                        SEQO_PP_LOW: begin
                            drv.pin_out = !on;
                            drv.pin_oe = 1'h1;
                        end
                        SEQO_PP_HIGH: begin
                            drv.pin_out = on;
                            drv.pin_oe = 1'h1;
                        end
                        // tracking loop owns the gate, pin logic releases
                        SEQO_TRACK: begin
                            if (CAN_TRACK) begin
                                drv.track_on = on;
                            end else begin
                                drv.bad_mode = 1'h1;
                            end
                        end
                        // pump drives gate high, pin sinks when off
                        SEQO_PUMP: begin
                            if (CAN_PUMP) begin
                                drv.pump_on = on;
                                drv.pin_out = 1'h0;
                                drv.pin_oe = !on;
                            end else begin
                                drv.bad_mode = 1'h1;
                            end
                        end
                        default: begin
                            drv.bad_mode = 1'h1;
                        end
                    endcase
                end
            end

            assign chan_if.drive = drv;

            seqo_out_stage u_stage (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .chan(chan_if.stage)
            );

            assign en_out_o[ch] = chan_if.pin_out;
            assign en_out_oe[ch] = chan_if.pin_oe;
            assign bad_mode[ch] = chan_if.bad_mode;
            if (CAN_PUMP) begin : g_pump
                assign pump_on[ch] = chan_if.pump_on;
            end
            if (CAN_TRACK) begin : g_track
                assign track_on[ch] = chan_if.track_on;
            end
        end
    endgenerate

    // tracking channels ask for their paired return-sense pin
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sense_req_r <= 4'h0;
        end else begin
            for (int i = 0; i < `SEQO_TRACK_CH; i++) begin
                sense_req_r[i] <= (code[i] == SEQO_TRACK);
            end
        end
    end

    assign sense_pair_req = sense_req_r;

endmodule : seqo_output_cfg

`default_nettype wire

// [hw/seqo_pkg.sv]
// types shared by the enable-output configuration block
`default_nettype none

package seqo_pkg;

    // drive mode codes as stored in the configuration fields
    typedef enum logic [2:0] {
        SEQO_OD_LOW = 3'h0,
        SEQO_OD_HIGH = 3'h1,
        SEQO_PP_LOW = 3'h2,
        SEQO_PP_HIGH = 3'h3,
        SEQO_TRACK = 3'h4,
        SEQO_PUMP = 3'h5,
        SEQO_RSVD6 = 3'h6,
        SEQO_RSVD7 = 3'h7
    } seqo_mode_t;

    // decoded pin behaviour of one channel
    typedef struct packed {
        logic pin_out;
        logic pin_oe;
        logic pump_on;
        logic track_on;
        logic bad_mode;
    } seqo_drive_t;

endpackage : seqo_pkg

`default_nettype wire
